// ===== hw/phy_reset_defs.svh
// Constants for the reset, strap latch and indicator block
`ifndef PHY_RESET_DEFS_SVH
`define PHY_RESET_DEFS_SVH
`define CLK_HZ 25000000
`define RESET_MIN_NS 1000
// Least low time in cycles, rounded up
`define RESET_MIN_CYC ((`RESET_MIN_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define BLINK_HALF_MS 50
`define BLINK_HALF_CYC (`BLINK_HALF_MS * (`CLK_HZ / 1000))
`define ADDR_W 5
`define ISO_ADDR 5'h00
`define STRAP_W 8
`define ADDR_LSB 0
`define AN_LSB 5
`define LEDM_BIT 7
`define STRAP_RST 8'h61
`define APB_CTRL 12'h000
`define APB_STAT 12'h004
`define CTRL_RST 32'h00000000
`endif

// ===== hw/phy_reset_pkg.sv
// Types shared by the reset, strap latch and indicator block
package phy_reset_pkg;
    typedef enum logic [1:0] {
        st_reset,
        st_latch,
        st_run
    } seq_state_t;
endpackage

// ===== hw/blink_gen.sv
// Free-running blink square wave for the activity indicator
`timescale 1ns/100ps
`include "phy_reset_defs.svh"
module blink_gen #(
    parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    output logic phase
);
    logic [31:0] cnt_q;

    // Toggle the phase every half period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 32'h0;
            phase <= 1'b0;
        end else if (cnt_q >= HALF_CYC - 1) begin
            cnt_q <= 32'h0;
            phase <= ~phase;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule

// ===== hw/phy_reset_strap_led_control.sv
// Reset sequencer, strap latch, APB registers and LED drive
`timescale 1ns/100ps
`include "phy_reset_defs.svh"
module phy_reset_strap_led_control #(
    parameter int unsigned BLINK_HALF = `BLINK_HALF_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pin_reset_n,
    input wire logic [7:0] strap_in,
    input wire logic link_good,
    input wire logic speed_100,
    input wire logic activity,
    input wire logic [7:0] func_out,
    output logic [7:0] strap_out,
    output logic [7:0] strap_oe_n,
    output logic link_indicator_out,
    output logic speed_indicator_out,
    output logic core_reset_n,
    output logic isolate,
    output logic [4:0] phy_address,
    output logic [1:0] an_mode,
    output logic led_mode2,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Synchronisers for pins from the board
    logic [1:0] rst_sync_q;
    logic [7:0] strap_s1_q;
    logic [7:0] strap_s2_q;
    logic [2:0] misc_s1_q;
    logic [2:0] misc_s2_q;
    phy_reset_pkg::seq_state_t state_q;
    logic [7:0] low_cnt_q;
    logic [7:0] strap_q;
    logic [4:0] addr_q;
    logic blink;
    logic release_w;

    // Pin reset long enough and now released; sequencer and latch share it
    function automatic logic release_seen(
        input phy_reset_pkg::seq_state_t st,
        input logic pin_high,
        input logic [7:0] low_cnt
    );
        return st == phy_reset_pkg::st_reset && pin_high &&
            low_cnt >= 8'(`RESET_MIN_CYC);
    endfunction

    // Register decode, shared by the write path and the read answer
    function automatic logic is_ctrl(input logic [11:0] a);
        return a == `APB_CTRL;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `APB_CTRL || a == `APB_STAT;
    endfunction

    // A pulse shorter than the minimum low time never makes this true
    assign release_w = release_seen(state_q, rst_sync_q[1], low_cnt_q);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
            strap_s1_q <= `STRAP_RST;
            strap_s2_q <= `STRAP_RST;
            misc_s1_q <= 3'h0;
            misc_s2_q <= 3'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], pin_reset_n};
            strap_s1_q <= strap_in;
            strap_s2_q <= strap_s1_q;
            misc_s1_q <= {activity, speed_100, link_good};
            misc_s2_q <= misc_s1_q;
        end
    end

    // Count low time of the reset pin; a short glitch does not reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_q <= 8'h0;
        end else if (rst_sync_q[1]) begin
            low_cnt_q <= 8'h0;
        end else if (low_cnt_q < 8'(`RESET_MIN_CYC)) begin
            low_cnt_q <= low_cnt_q + 8'h1;
        end
    end

    // Sequencer: pin reset, latch on release, then run
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= phy_reset_pkg::st_reset;
        end else begin
            case (state_q)
                phy_reset_pkg::st_reset: begin
                    if (release_w) begin
                        state_q <= phy_reset_pkg::st_latch;
                    end
                end
                phy_reset_pkg::st_latch: begin
                    state_q <= phy_reset_pkg::st_run;
                end
                phy_reset_pkg::st_run: begin
                    if (low_cnt_q >= 8'(`RESET_MIN_CYC) - 8'h1 &&
                        !rst_sync_q[1]) begin
                        state_q <= phy_reset_pkg::st_reset;
                    end
                end
                default: state_q <= phy_reset_pkg::st_reset;
            endcase
        end
    end

    // Strap latch on release; every reset relatches, never kept
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_q <= `STRAP_RST;
        end else if (release_w) begin
            strap_q <= strap_s2_q;
        end
    end

    // Mode outputs; isolate only from the strapped address
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            isolate <= 1'b0;
            an_mode <= 2'h3;
            led_mode2 <= 1'b1;
            core_reset_n <= 1'b0;
        end else begin
            isolate <= strap_q[`ADDR_LSB +: `ADDR_W] == `ISO_ADDR;
            an_mode <= strap_q[`AN_LSB +: 2];
            led_mode2 <= strap_q[`LEDM_BIT];
            core_reset_n <= state_q == phy_reset_pkg::st_run;
        end
    end

    // Pins float as inputs during reset, then drive functions
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_oe_n <= 8'hff;
            strap_out <= 8'h00;
        end else begin
            strap_oe_n <= {8{state_q != phy_reset_pkg::st_run}};
            strap_out <= func_out;
        end
    end

    // Address register: software may rewrite it, isolate unaffected
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= 5'h00;
        end else if (state_q == phy_reset_pkg::st_latch) begin
            addr_q <= strap_q[`ADDR_LSB +: `ADDR_W];
        end else if (state_q == phy_reset_pkg::st_reset) begin
            addr_q <= 5'h00;
        end else if (psel && penable && pwrite && is_ctrl(paddr)) begin
            addr_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phy_address <= 5'h00;
        end else begin
            phy_address <= addr_q;
        end
    end

    blink_gen #(.HALF_CYC(BLINK_HALF)) u_blink (
        .mclk(mclk),
        .reset_n(reset_n),
        .phase(blink)
    );

    // LEDs active high; blink only while active in mode 2
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link_indicator_out <= 1'b0;
            speed_indicator_out <= 1'b0;
        end else if (state_q != phy_reset_pkg::st_run) begin
            link_indicator_out <= 1'b0;
            speed_indicator_out <= 1'b0;
        end else begin
            if (led_mode2 && misc_s2_q[2]) begin
                link_indicator_out <= misc_s2_q[0] & blink;
            end else begin
                link_indicator_out <= misc_s2_q[0];
            end
            speed_indicator_out <= misc_s2_q[1];
        end
    end

    // APB slave: no wait states, unmapped reads zero with error
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !is_mapped(paddr);
            case (paddr)
                `APB_CTRL: prdata <= {27'h0, addr_q};
                `APB_STAT: prdata <= {24'h0, strap_q[7:5], isolate,
                    state_q == phy_reset_pkg::st_run,
                    misc_s2_q};
                default: prdata <= 32'h0;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Checks

    // Latched straps stay put while the pins carry functions
    strap_hold_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run |=> $stable(strap_q))
        else $error("strap value changed while running");

    // Isolate follows only the strapped address
    iso_zero_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ##1 isolate == ($past(strap_q[4:0]) == 5'h00))
        else $error("isolate does not follow strapped zero");

    // A register write cannot move isolate
    write_iso_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $stable(strap_q) && state_q == phy_reset_pkg::st_run
        |=> $stable(isolate))
        else $error("write changed isolate");

    // Pins float while reset is in force
    pin_dir_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q != phy_reset_pkg::st_run |=> strap_oe_n == 8'hff)
        else $error("strap pins driven in reset");

    // Pins drive again once running
    pin_run_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run |=> strap_oe_n == 8'h00)
        else $error("strap pins not driven when running");

    // Speed indicator tracks the rate whatever the LED mode
    speed_led_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run
        |=> speed_indicator_out == $past(misc_s2_q[1]))
        else $error("speed indicator wrong");

    // No link, no light in either mode
    link_off_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run && !misc_s2_q[0]
        |=> !link_indicator_out)
        else $error("link indicator on without link");

    // Mode 1 shows the link level steadily
    link_mode1_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run && !led_mode2 && misc_s2_q[0]
        |=> link_indicator_out)
        else $error("mode 1 link indicator off");

    // Mode 2 with traffic shows the blink phase
    blink_link_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run && led_mode2 &&
        misc_s2_q[2] && misc_s2_q[0]
        |=> link_indicator_out == $past(blink))
        else $error("mode 2 indicator does not blink");

    // Both indicators dark outside the running state
    led_dark_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q != phy_reset_pkg::st_run
        |=> !link_indicator_out && !speed_indicator_out)
        else $error("indicator lit during reset");

    // Core held in reset while the pin sequence runs
    reset_seq_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_reset |=> !core_reset_n)
        else $error("core left reset during pin reset");

    // A high pin never drops the running state
    pin_high_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_run && rst_sync_q[1]
        |=> state_q == phy_reset_pkg::st_run)
        else $error("left running with the pin high");

    // Each release takes fresh pin levels
    strap_take_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        release_w |=> strap_q == $past(strap_s2_q))
        else $error("straps not relatched on release");

    // Before release the latch waits
    strap_wait_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_reset && !release_w
        |=> $stable(strap_q))
        else $error("straps latched before release");

    // Address field starts from the straps
    addr_load_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_latch |=> addr_q == $past(strap_q[4:0]))
        else $error("address not loaded from straps");

    // Address field cleared while the pin reset lasts
    addr_clear_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == phy_reset_pkg::st_reset |=> addr_q == 5'h00)
        else $error("address not cleared in reset");

    // Address output is the register one cycle on
    phy_out_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ##1 phy_address == $past(addr_q))
        else $error("address output lags wrongly");
endmodule

// ===== tb/board_model.sv
// Board side model: reset source and strap resistors on dual-use pins
`timescale 1ns/100ps
module board_model (
    input wire logic mclk,
    input wire logic [7:0] strap_out,
    input wire logic [7:0] strap_oe_n,
    output logic pin_reset_n,
    output logic [7:0] strap_in
);
    logic [7:0] strap_q = 8'h61;

    initial pin_reset_n = 1'b1;

    // Released pins sit at the resistor level, driven pins follow the chip
    assign strap_in = (strap_oe_n & strap_q) | (~strap_oe_n & strap_out);

    // Pin held low for n cycles; at 25 MHz, 25 cycles make the 1 us minimum
    task pulse(input int n, input logic [7:0] s);
        @(posedge mclk);
        strap_q <= s;
        pin_reset_n <= 1'b0;
        repeat (n) @(posedge mclk);
        pin_reset_n <= 1'b1;
    endtask
endmodule

// ===== tb/phy_reset_strap_led_control_bench.sv
// Bench for the reset sequencer, strap latch, registers and LED drive
`timescale 1ns/100ps
`include "phy_reset_defs.svh"
module phy_reset_strap_led_control_bench;
    logic mclk, reset_n, pin_reset_n, link_good, speed_100, activity;
    logic psel, penable, pwrite, pready, pslverr, er, isolate, led_mode2;
    logic link_indicator_out, speed_indicator_out, core_reset_n;
    logic [7:0] func_out, strap_in, strap_out, strap_oe_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] phy_address;
    logic [1:0] an_mode;
    logic [7:0] tbl [4] = '{8'h00, 8'h9f, 8'h41, 8'hca};
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int ones;

    // Short blink half period keeps the activity test brief
    phy_reset_strap_led_control #(.BLINK_HALF(4)) phy_reset_strap_led_control_i (
        .mclk, .reset_n, .pin_reset_n, .strap_in, .link_good, .speed_100,
        .activity, .func_out, .strap_out, .strap_oe_n, .link_indicator_out,
        .speed_indicator_out, .core_reset_n, .isolate, .phy_address,
        .an_mode, .led_mode2, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr
    );

    board_model board_model_i (
        .mclk, .strap_out, .strap_oe_n, .pin_reset_n, .strap_in
    );

    // 25 MHz reference clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task close_out;
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under this
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            close_out;
        end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high, for at most 50 cycles
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin reset; the look one cycle before the pin rises only makes sense for a long pulse
    task reset_pin(input int n, input logic [7:0] s);
        fork
            board_model_i.pulse(n, s);
            begin
                repeat (n) @(posedge mclk);
                if (n > 25) begin
                    check("oe_n_in_reset", strap_oe_n, 8'hff);
                    check("core_in_reset", core_reset_n, 1'b0);
                end
            end
        join
        for (int k = 0; k < 200 && core_reset_n !== 1'b1; k++) @(posedge mclk);
        repeat (10) @(posedge mclk);
    endtask

    task settle;
        repeat (6) @(posedge mclk);
    endtask

    initial begin
        reset_n = 1'b0;
        {link_good, speed_100, activity, psel, penable, pwrite} = 6'h00;
        func_out = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (tbl[i]) begin
            reset_pin(30, tbl[i]);
            check("addr", phy_address, tbl[i][4:0]);
            check("iso", isolate, tbl[i][4:0] == 5'h00);
            check("an", an_mode, tbl[i][6:5]);
            check("mode", led_mode2, tbl[i][7]);
            check("oe_n_run", strap_oe_n, 8'h00);
            link_good <= 1'b1;
            speed_100 <= 1'b1;
            settle;
            check("link_on", link_indicator_out, 1'b1);
            check("spd_on", speed_indicator_out, 1'b1);
            speed_100 <= 1'b0;
            settle;
            check("spd_off", speed_indicator_out, 1'b0);
            link_good <= 1'b0;
            settle;
            check("link_off", link_indicator_out, 1'b0);
            link_good <= 1'b1;
            activity <= 1'b1;
            settle;
            ones = 0;
            repeat (16) begin
                @(posedge mclk);
                ones += link_indicator_out === 1'b1;
            end
            check("blink", ones > 0 && ones < 16, tbl[i][7]);
            activity <= 1'b0;
        end
        // Pins now drive functional values; latched address must hold
        func_out <= 8'h15;
        repeat (4) @(posedge mclk);
        check("func", strap_out, 8'h15);
        check("hold", phy_address, 5'h0a);
        reset_pin(10, 8'h05);
        check("short", phy_address, 5'h0a);
        check("short_core", core_reset_n, 1'b1);
        apb(1'b0, `APB_CTRL, 32'h0);
        check("ctrl", rd, 32'h0000000a);
        apb(1'b1, `APB_CTRL, 32'h0);
        apb(1'b0, `APB_CTRL, 32'h0);
        check("ctrl_w0", rd, 32'h00000000);
        check("iso_w0", isolate, 1'b0);
        apb(1'b0, `APB_STAT, 32'h0);
        check("stat", rd[4:3], 2'b01);
        apb(1'b0, 12'h008, 32'h0);
        check("unmap_err", er, 1'b1);
        check("unmap_rd", rd, 32'h00000000);
        reset_pin(30, 8'h63);
        apb(1'b0, `APB_CTRL, 32'h0);
        check("ctrl_rst", rd, 32'h00000003);
        check("iso_rst", isolate, 1'b0);
        close_out;
    end
endmodule
